// ===== src/tpw_timer.v
// Timer channel in pulse width modulation mode with Avalon-MM registers
`timescale 1ns/1ns
`include "tpw_map.vh"

module tpw_timer (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_n_in,
    // Avalon-MM slave
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    // Count sources and triggers
    input wire subclock_in,
    input wire other_timer_ovf_in,
    input wire trigger_input_pin_in,
    // Pulse and interrupt request
    output wire pulse_output_pin_out,
    output reg irq_req_out
);

//=====================================================================
// Functions

    // Merge one write byte lane into a stored byte
    function [7:0] lane;
        input [7:0] old;
        input [7:0] new_b;
        input en;
        begin
            lane = en ? new_b : old;
        end
    endfunction

    // Decrement by one that wraps from zero to all ones
    function [15:0] dec;
        input [15:0] v;
        begin
            dec = v - 16'h0001;
        end
    endfunction

//=====================================================================
// Registers

    reg [7:0] ctrl_r;
    reg [15:0] rel_r;
    reg [15:0] cnt_r;
    reg [7:0] pre_r;
    reg hi_r;
    reg run_r;
    reg ack_r;
    reg [4:0] div_r;
    reg [4:0] sub_cnt_r;
    reg sub_prev_r;
    reg pin_prev_r;
    reg [15:0] cur_r;

    wire start_flag;
    wire mode8;
    wire [1:0] clk_sel;
    wire [1:0] trg_sel;
    wire go;

    assign start_flag = ctrl_r[`TPW_CTRL_START];
    assign mode8 = ctrl_r[`TPW_CTRL_MODE8];
    assign clk_sel = ctrl_r[`TPW_CTRL_CLK_LSB+1:`TPW_CTRL_CLK_LSB];
    assign trg_sel = ctrl_r[`TPW_CTRL_TRG_LSB+1:`TPW_CTRL_TRG_LSB];

//=====================================================================
// Bus decode

    wire bus_req;
    wire wr_take;
    wire rd_take;
    wire sel_ctrl;
    wire sel_value;
    wire sel_stat;

    // One wait state: every access is answered at its second edge
    // Writes land on the edge that ends the wait; reads latch a cycle
    // early so the data already stands when waitrequest drops
    assign bus_req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = bus_req & ~ack_r;
    assign wr_take = avs_write_in & ack_r;
    assign rd_take = avs_read_in & ~ack_r;
    assign sel_ctrl = (avs_address_in == `TPW_CTRL_OFS);
    assign sel_value = (avs_address_in == `TPW_VALUE_OFS);
    assign sel_stat = (avs_address_in == `TPW_STAT_OFS);

    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req & ~ack_r;
        end
    end

//=====================================================================
// Count clock selection

    wire sub_rise;
    wire tick_div8;
    wire tick_div32;
    wire tick_sub32;
    reg tick;

    assign sub_rise = subclock_in & ~sub_prev_r;
    assign tick_div8 = (div_r[2:0] == `TPW_DIV8_LAST);
    assign tick_div32 = (div_r == `TPW_DIV32_LAST);
    assign tick_sub32 = sub_rise & (sub_cnt_r == `TPW_DIV32_LAST);

    // Dividers restart with each start so the first high phase is full
    // length; the sub-clock is sampled, so its phase may take one cycle off the first tick
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            div_r <= 5'h00;
            sub_cnt_r <= 5'h00;
            sub_prev_r <= 1'b0;
        end else if (go) begin
            div_r <= 5'h00;
            sub_cnt_r <= 5'h00;
            sub_prev_r <= subclock_in;
        end else begin
            div_r <= div_r + 5'h01;
            sub_prev_r <= subclock_in;
            if (sub_rise) begin
                sub_cnt_r <= sub_cnt_r + 5'h01;
            end
        end
    end

    always @* begin
        case (clk_sel)
            `TPW_CLK_UNDIV: tick = 1'b1;
            `TPW_CLK_DIV8: tick = tick_div8;
            `TPW_CLK_DIV32: tick = tick_div32;
            `TPW_CLK_SUB32: tick = tick_sub32;
            default: tick = 1'b0;
        endcase
    end

//=====================================================================
// Trigger detection

    wire pin_rise;
    wire pin_fall;
    reg trig_evt;

    assign pin_rise = trigger_input_pin_in & ~pin_prev_r;
    assign pin_fall = ~trigger_input_pin_in & pin_prev_r;

    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= trigger_input_pin_in;
        end
    end

    always @* begin
        case (trg_sel)
            `TPW_TRG_NONE: trig_evt = 1'b1;
            `TPW_TRG_FALL: trig_evt = pin_fall;
            `TPW_TRG_RISE: trig_evt = pin_rise;
            `TPW_TRG_OVF: trig_evt = other_timer_ovf_in;
            default: trig_evt = 1'b0;
        endcase
    end

//=====================================================================
// Phase values

    wire [15:0] full;
    wire [15:0] width;
    wire [15:0] cur_w;
    wire [15:0] low_len;
    wire [7:0] pre_m;
    wire special;
    wire unit_tick;
    wire phase_end;
    wire reload;

    // 8-bit mode: width is the upper byte, prescaler the lower
    assign full = mode8 ? `TPW_FULL8 : `TPW_FULL16;
    assign width = mode8 ? {8'h00, rel_r[15:8]} : rel_r;
    // The running period keeps its own copy, so a write while counting
    // cannot bend the period it lands in
    assign cur_w = mode8 ? {8'h00, cur_r[15:8]} : cur_r;
    assign pre_m = cur_r[7:0];
    assign low_len = full ^ cur_w;
    assign special = (cur_w == 16'h0000) | (cur_w == full);
    assign unit_tick = tick & (~mode8 | (pre_r == 8'h00));
    assign phase_end = unit_tick & (cnt_r == 16'h0001);
    assign go = start_flag & ~run_r & trig_evt;
    assign reload = go | (run_r & phase_end &
        ~(hi_r & (low_len != 16'h0000)));

//=====================================================================
// Counter and pulse

    reg [15:0] cnt_nxt;
    reg hi_nxt;
    reg run_nxt;
    reg irq_nxt;

    always @* begin
        cnt_nxt = cnt_r;
        hi_nxt = hi_r;
        run_nxt = run_r;
        irq_nxt = 1'b0;
        if (!start_flag) begin
            run_nxt = 1'b0;
            hi_nxt = 1'b0;
        end else if (go) begin
            run_nxt = 1'b1;
            if (width == 16'h0000) begin
                hi_nxt = 1'b0;
                cnt_nxt = full;
            end else begin
                hi_nxt = 1'b1;
                cnt_nxt = width;
            end
        end else if (run_r && phase_end) begin
            if (hi_r && low_len != 16'h0000) begin
                hi_nxt = 1'b0;
                cnt_nxt = low_len;
                irq_nxt = ~special;
            end else if (width == 16'h0000) begin
                hi_nxt = 1'b0;
                cnt_nxt = full;
            end else begin
                hi_nxt = 1'b1;
                cnt_nxt = width;
            end
        end else if (run_r && unit_tick) begin
            cnt_nxt = dec(cnt_r);
            irq_nxt = special & (cnt_r == 16'h0002);
        end
    end

    // Pulse comes from a flip-flop so the pin never glitches
    assign pulse_output_pin_out = hi_r;

    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            cnt_r <= `TPW_VALUE_RST;
            hi_r <= 1'b0;
            run_r <= 1'b0;
            irq_req_out <= 1'b0;
        end else begin
            hi_r <= hi_nxt;
            run_r <= run_nxt;
            irq_req_out <= irq_nxt;
            if (wr_take && sel_value && !run_r) begin
                cnt_r[7:0] <= lane(cnt_r[7:0], avs_writedata_in[7:0],
                    avs_byteenable_in[0]);
                cnt_r[15:8] <= lane(cnt_r[15:8], avs_writedata_in[15:8],
                    avs_byteenable_in[1]);
            end else begin
                cnt_r <= cnt_nxt;
            end
        end
    end

//=====================================================================
// Reload copy

    // Taken at each reload point only
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            cur_r <= `TPW_VALUE_RST;
        end else if (reload) begin
            cur_r <= rel_r;
        end
    end

//=====================================================================
// Prescaler

    // Reloaded with each rising edge too, so the new m applies cleanly
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            pre_r <= 8'h00;
        end else if (reload) begin
            pre_r <= rel_r[7:0];
        end else if (run_r && tick) begin
            if (pre_r == 8'h00) begin
                pre_r <= pre_m;
            end else begin
                pre_r <= pre_r - 8'h01;
            end
        end
    end

//=====================================================================
// Register writes

    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            ctrl_r <= `TPW_CTRL_RST;
            rel_r <= `TPW_VALUE_RST;
        end else if (wr_take) begin
            if (sel_ctrl) begin
                ctrl_r <= lane(ctrl_r, avs_writedata_in[7:0],
                    avs_byteenable_in[0]);
            end
            if (sel_value) begin
                rel_r[7:0] <= lane(rel_r[7:0], avs_writedata_in[7:0],
                    avs_byteenable_in[0]);
                rel_r[15:8] <= lane(rel_r[15:8], avs_writedata_in[15:8],
                    avs_byteenable_in[1]);
            end
        end
    end

//=====================================================================
// Register reads

    wire [31:0] stat_word;
    wire armed;

    assign armed = start_flag & ~run_r;
    assign stat_word = {28'h0000000, armed, trigger_input_pin_in,
        hi_r, run_r};

    // Unmapped addresses read as zero
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            avs_readdata_out <= 32'h00000000;
        end else if (rd_take) begin
            if (sel_ctrl) begin
                avs_readdata_out <= {24'h000000, ctrl_r};
            end else if (sel_value) begin
                avs_readdata_out <= `TPW_UNDEF_VAL;
            end else if (sel_stat) begin
                avs_readdata_out <= stat_word;
            end else begin
                avs_readdata_out <= 32'h00000000;
            end
        end
    end

endmodule

// ===== src/tpw_map.vh
// Register map and field constants of the timer PWM unit
//=====================================================================
`ifndef TPW_MAP_VH
`define TPW_MAP_VH

//=====================================================================
// Register byte offsets
`define TPW_CTRL_OFS 4'h0
`define TPW_VALUE_OFS 4'h4
`define TPW_STAT_OFS 4'h8

//=====================================================================
// Control fields
`define TPW_CTRL_START 0
`define TPW_CTRL_MODE8 1
`define TPW_CTRL_CLK_LSB 2
`define TPW_CTRL_TRG_LSB 4
`define TPW_CTRL_RST 8'h00
`define TPW_VALUE_RST 16'h0000

//=====================================================================
// Status fields
`define TPW_STAT_RUN 0
`define TPW_STAT_PULSE 1
`define TPW_STAT_PIN 2
`define TPW_STAT_ARMED 3

//=====================================================================
// Count clock and trigger codes
`define TPW_CLK_UNDIV 2'h0
`define TPW_CLK_DIV8 2'h1
`define TPW_CLK_DIV32 2'h2
`define TPW_CLK_SUB32 2'h3
`define TPW_TRG_NONE 2'h0
`define TPW_TRG_FALL 2'h1
`define TPW_TRG_RISE 2'h2
`define TPW_TRG_OVF 2'h3

//=====================================================================
// Counts
`define TPW_DIV8_LAST 5'h07
`define TPW_DIV32_LAST 5'h1f
`define TPW_FULL16 16'hffff
`define TPW_FULL8 16'h00ff
`define TPW_UNDEF_VAL 32'h00000000

`endif

// ===== testbench/tpw_load_model.sv
// Load model that times the pulse seen on the output pin
`timescale 1ns/1ns

module tpw_load_model (
    // Clock
    input wire logic clk_in,
    // Pulse from the device
    input wire logic pulse_in,
    // High time and period of the last full cycle, in clock cycles
    output logic done_out,
    output logic [31:0] hi_out,
    output logic [31:0] per_out
);
    logic prev_r = 1'b0;
    logic seen_r = 1'b0;
    logic [31:0] cnt_r = 32'h0;

    // Edges are seen one cycle late, which cancels out in every span
    always @(posedge clk_in) begin
        prev_r <= pulse_in;
        done_out <= pulse_in && !prev_r && seen_r;
        if (pulse_in && !prev_r) begin
            per_out <= cnt_r;
            seen_r <= 1'b1;
            cnt_r <= 32'h1;
        end else
            cnt_r <= cnt_r + 32'h1;
        if (!pulse_in && prev_r)
            hi_out <= cnt_r;
    end
endmodule

// ===== testbench/tpw_timer_chk.sv
// Assertion checker for the timer PWM unit
`timescale 1ns/1ns
`include "tpw_map.vh"

module tpw_timer_chk (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Register bus
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // Pins
    input wire logic subclock_in,
    input wire logic other_timer_ovf_in,
    input wire logic trigger_input_pin_in,
    input wire logic pulse_output_pin_out,
    input wire logic irq_req_out
);
    //=================================================================
    // Shadow of what software wrote, plus the delayed pulse and its period count
    logic start_r, mode8_r, pul_d_r, per_ok_r;
    logic [1:0] clk_r;
    logic [15:0] val_r;
    logic [16:0] per_r;
    wire wr_ok = avs_write_in && !avs_waitrequest_out;
    wire rise_w = pulse_output_pin_out && !pul_d_r;
    wire zero_w = mode8_r ? val_r[15:8] == 8'h00 : val_r == 16'h0000;
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            {start_r, mode8_r, pul_d_r, per_ok_r} <= 4'h0;
            clk_r <= 2'h0;
            val_r <= 16'h0000;
            per_r <= 17'h00000;
        end else begin
            pul_d_r <= pulse_output_pin_out;
            per_r <= rise_w ? 17'h00001 : per_r + 17'h00001;
            // Only a full period at the undivided clock is judged
            per_ok_r <= rise_w ? start_r && !mode8_r && clk_r == 2'h0
                : per_ok_r && start_r && !mode8_r;
            if (wr_ok && avs_address_in == `TPW_CTRL_OFS) begin
                start_r <= avs_writedata_in[`TPW_CTRL_START];
                mode8_r <= avs_writedata_in[`TPW_CTRL_MODE8];
                clk_r <= avs_writedata_in[3:2];
            end
            if (wr_ok && avs_address_in == `TPW_VALUE_OFS)
                val_r <= avs_writedata_in[15:0];
        end
    end
    //=================================================================
    // Properties
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_wait_first: assert property ($rose(avs_read_in || avs_write_in)
        |-> avs_waitrequest_out) else $error("no wait state");
    a_wait_once: assert property ((avs_read_in || avs_write_in) &&
        avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("second wait state");
    a_value_undef: assert property (avs_read_in && !avs_waitrequest_out
        && avs_address_in == `TPW_VALUE_OFS
        |-> avs_readdata_out == `TPW_UNDEF_VAL) else $error("live count");
    a_irq_at_fall: assert property ($fell(pulse_output_pin_out)
        && start_r |-> irq_req_out) else $error("no irq at fall");
    a_irq_single: assert property (irq_req_out |=> !irq_req_out)
        else $error("irq longer than one cycle");
    a_stop_low: assert property (!start_r && !$past(start_r)
        |-> !pulse_output_pin_out) else $error("pulse while stopped");
    a_zero_low: assert property (zero_w && $past(zero_w)
        |-> !rise_w) else $error("pulse rose at zero width");
    a_rise_start: assert property (rise_w |-> start_r)
        else $error("pulse rose without start");
    a_period_fix: assert property (rise_w && per_ok_r
        |-> per_r == 17'h0ffff) else $error("wrong 16-bit period");
    c_period: cover property (rise_w && per_ok_r);
    c_irq_fall: cover property ($fell(pulse_output_pin_out) && irq_req_out);
    c_val_read: cover property (avs_read_in && !avs_waitrequest_out &&
        avs_address_in == `TPW_VALUE_OFS);
endmodule

bind tpw_timer tpw_timer_chk u_chk (.*);

// ===== testbench/testbench.sv
// Self-checking testbench for the timer PWM unit
`timescale 1ns/1ns
`include "tpw_map.vh"

module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic sub = 1'b0;
    logic ovf = 1'b0;
    logic pin = 1'b0;
    logic [31:0] rdata, hi_len, per_len;
    logic waitreq, pulse, irq, done;
    integer failures = 0;
    integer checked = 0;
    integer seed = 77371;
    integer n, m, f, k, irqs;
    logic [31:0] rq[$];
    logic [63:0] pq[$];

    always #50 clk = ~clk;
    // Sub-clock rises every second cycle
    always @(posedge clk) sub <= ~sub;

    tpw_timer u_dut (
        .ref_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .subclock_in(sub),
        .other_timer_ovf_in(ovf), .trigger_input_pin_in(pin),
        .pulse_output_pin_out(pulse), .irq_req_out(irq));
    tpw_load_model u_load (.clk_in(clk), .pulse_in(pulse),
        .done_out(done), .hi_out(hi_len), .per_out(per_len));

    //=================================================================
    // Shared tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
            input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk);
        while (waitreq !== 1'b0);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic poke(input logic [1:0] t);
        @(posedge clk);
        pin <= (t != `TPW_TRG_RISE);
        repeat (3) @(posedge clk);
        pin <= (t == `TPW_TRG_RISE);
        ovf <= (t == `TPW_TRG_OVF);
        @(posedge clk);
        ovf <= 1'b0;
    endtask
    task automatic run(input logic [7:0] c, input logic [63:0] e1,
            input logic [15:0] nv, input logic [63:0] e2);
        // Start on a known sub-clock phase so the first divided tick is full
        while (sub !== 1'b1) @(posedge clk);
        bus(1'b1, `TPW_CTRL_OFS, {24'h0, c});
        if (c[5:4] != `TPW_TRG_NONE) begin
            repeat (20) @(posedge clk);
            check({63'h0, pulse}, 64'h0);
            poke(c[5:4]);
        end
        while (pulse !== 1'b1) @(posedge clk);
        repeat (2) @(posedge clk);
        pq.push_back(e1);
        if (nv != 16'h0) begin
            bus(1'b1, `TPW_VALUE_OFS, {16'h0, nv});
            pq.push_back(e2);
        end
        // A restart here would stretch the measured period
        poke(c[5:4]);
        while (pq.size() > 0) @(posedge clk);
        bus(1'b1, `TPW_CTRL_OFS, 32'h0);
    endtask
    task automatic final_report;
        $display("checks=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    //=================================================================
    // Result watcher
    always @(posedge clk) begin
        if (rd && waitreq === 1'b0 && rq.size() > 0)
            check({32'h0, rdata}, {32'h0, rq.pop_front()});
        if (done === 1'b1 && pq.size() > 0)
            check({hi_len, per_len}, pq.pop_front());
    end

    //=================================================================
    // Scenarios
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(`TPW_CTRL_OFS, {24'h0, `TPW_CTRL_RST});
        rdchk(`TPW_STAT_OFS, 32'h0);
        rdchk(4'hc, 32'h0);
        bus(1'b1, `TPW_VALUE_OFS, 32'h3);
        rdchk(`TPW_VALUE_OFS, `TPW_UNDEF_VAL);
        rdchk(`TPW_CTRL_OFS, {24'h0, `TPW_CTRL_RST});
        $display("test registers done");
        run(8'h01, {32'd3, 32'd65535}, 16'h0, 64'h0);
        $display("test 16-bit done");
        for (k = 0; k < 4; k++) begin
            f = (k == 0) ? 1 : (k == 1) ? 8 : (k == 2) ? 32 : 64;
            m = (k == 0) ? ($random(seed) & 3) : 0;
            n = 1 + (($random(seed) & 255) % 254);
            bus(1'b1, `TPW_VALUE_OFS, {16'h0, n[7:0], m[7:0]});
            run({4'h0, k[1:0], 2'b11}, {n * (m + 1) * f, 255 * (m + 1) * f},
                (k == 0) ? {8'(255 - n), m[7:0]} : 16'h0,
                {(255 - n) * (m + 1) * f, 255 * (m + 1) * f});
        end
        $display("test 8-bit done");
        for (k = 1; k < 4; k++) begin
            n = 1 + (($random(seed) & 255) % 254);
            bus(1'b1, `TPW_VALUE_OFS, {16'h0, n[7:0], 8'h00});
            run({2'h0, k[1:0], 4'h3}, {n, 32'd255}, 16'h0, 64'h0);
        end
        $display("test triggers done");
        bus(1'b1, `TPW_VALUE_OFS, 32'h0);
        bus(1'b1, `TPW_CTRL_OFS, 32'h03);
        irqs = 0;
        repeat (600) begin
            @(posedge clk);
            irqs = irqs + irq;
        end
        check({63'h0, pulse}, 64'h0);
        check({63'h0, irqs != 0}, 64'h1);
        bus(1'b1, `TPW_CTRL_OFS, 32'h0);
        $display("test zero width done");
        final_report;
    end

    initial begin
        repeat (140000) @(posedge clk);
        failures++;
        final_report;
    end
endmodule
